// ===== core/afe_register_map_readout.sv
`timescale 1ns/100ps
// What this block does
// - Every register is one byte, reachable alone by its own address.
// - Channel 0 result at 0x00..0x02, read only, MSB at lowest address.
// - Channel 1 result at 0x03..0x05, read only, MSB first.
// - Read/write bytes at 0x07, 0x08, 0x09, 0x0A and 0x0B.
// - Read mode field picks which address set a continuous read walks.
// - Mode 11 walks 0x00..0x0B, skipping 0x06 and leaving out 0x0C and 0x0D, and loops to its start.
// - Mode 01 loops within a group, mode 10 within a register type.
// - Results hold newest conversion per channel; host writes do nothing.
// - Result bytes read singly or chained by the read mode field.
// - Start of a read latches results into a holding copy.
// - Conversion during a read still captured, shifted bytes stay intact.
// - All three result bytes refresh together on the sample rate tick.
// - Ready select 00: strobe only when both channels have a new sample.
module afe_register_map_readout
  import afe_regs_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic cont_in,
  output logic [7:0] rdata_out,
  // Conversion results from the modulator filters
  input wire logic conv0_valid_in,
  input wire logic [23:0] conv0_data_in,
  input wire logic conv1_valid_in,
  input wire logic [23:0] conv1_data_in,
  input wire logic sample_rate_tick_in,
  // Events
  output logic conversion_ready_strobe_out,
  output logic irq_out,
  // Configuration towards the analog side
  output logic [7:0] interchannel_delay_out,
  output logic [7:0] amp_setting_out,
  output logic [7:0] setup_one_out,
  output logic [7:0] setup_two_out
);

  typedef enum logic [1:0] {
    IDLE = 2'b01,
    READING = 2'b10
  } session_e;

  typedef struct packed {
    session_e session;
    logic [RESULT_W-1:0] live0;
    logic [RESULT_W-1:0] live1;
    logic [RESULT_W-1:0] pend0;
    logic [RESULT_W-1:0] pend1;
    logic pnew0;
    logic pnew1;
    logic [RESULT_W-1:0] hold0;
    logic [RESULT_W-1:0] hold1;
    logic [CFG_COUNT-1:0][BYTE_W-1:0] cfg;
    logic [3:0] ptr;
    logic [BYTE_W-1:0] rdata;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic strobe;
  } state_s;

  state_s st;
  state_s next_st;

  logic [3:0] eff_addr;
  logic [1:0] read_mode;
  logic [1:0] ready_sel;
  logic both_new;
  logic upd0;
  logic upd1;
  logic ready_event;

  // Index of a configuration byte
  function automatic logic [2:0] cfg_index(input logic [3:0] a);
    logic [3:0] d;
    d = a - ADDR_INTERCHANNEL_DELAY;
    return d[2:0];
  endfunction : cfg_index

  // Byte of a 24-bit result, MSB at the lowest offset
  function automatic logic [7:0] result_byte(input logic [23:0] v, input logic [1:0] off);
    logic [7:0] b;
    unique case (off)
      2'h0: b = v[23:16];
      2'h1: b = v[15:8];
      default: b = v[7:0];
    endcase
    return b;
  endfunction : result_byte

  // First and last address of the set walked in a mode
  function automatic logic [7:0] walk_bounds(input logic [3:0] a, input logic [1:0] mode);
    logic [3:0] first;
    logic [3:0] last;
    first = a;
    last = a;
    unique case (mode)
      READ_GROUP: begin
        if (a < ADDR_CHAN1_RESULT) begin
          first = ADDR_CHAN0_RESULT;
          last = ADDR_CHAN1_RESULT - 4'h1;
        end else if (a < ADDR_RESERVED_SLOT) begin
          first = ADDR_CHAN1_RESULT;
          last = ADDR_RESERVED_SLOT - 4'h1;
        end else if (a >= ADDR_LINK_STATE_CONTROL && a <= ADDR_SETUP_TWO) begin
          first = ADDR_LINK_STATE_CONTROL;
          last = ADDR_SETUP_TWO;
        end
      end
      READ_TYPE: begin
        if (a < ADDR_RESERVED_SLOT) begin
          first = ADDR_CHAN0_RESULT;
          last = ADDR_RESERVED_SLOT - 4'h1;
        end else if (a <= ADDR_SETUP_TWO) begin
          first = ADDR_INTERCHANNEL_DELAY;
          last = ADDR_SETUP_TWO;
        end
      end
      READ_ALL: begin
        if (a <= ADDR_LAST_MAPPED) begin
          first = ADDR_CHAN0_RESULT;
          last = ADDR_LAST_MAPPED;
        end
      end
      default: begin
        first = a;
        last = a;
      end
    endcase
    return {first, last};
  endfunction : walk_bounds

  // Pointer after one byte of a continuous read
  function automatic logic [3:0] next_addr(input logic [3:0] a, input logic [1:0] mode);
    logic [7:0] bounds;
    logic [3:0] n;
    bounds = walk_bounds(a, mode);
    if (a == bounds[3:0]) begin
      n = bounds[7:4];
    end else begin
      n = a + 4'h1;
    end
    if (n == ADDR_RESERVED_SLOT) begin
      n = ADDR_INTERCHANNEL_DELAY;
    end
    return n;
  endfunction : next_addr

  // Read data mux over held results and registers
  function automatic logic [7:0] read_byte(input logic [3:0] a, input state_s s);
    logic [7:0] b;
    b = 8'h00;
    if (a < ADDR_CHAN1_RESULT) begin
      b = result_byte(s.hold0, a[1:0]);
    end else if (a < ADDR_RESERVED_SLOT) begin
      b = result_byte(s.hold1, 2'(a - ADDR_CHAN1_RESULT));
    end else if (a >= ADDR_INTERCHANNEL_DELAY && a <= ADDR_SETUP_TWO) begin
      b = s.cfg[cfg_index(a)];
    end else if (a == ADDR_IRQ_STATUS) begin
      b = {5'h00, s.irq_status};
    end else if (a == ADDR_IRQ_MASK) begin
      b = {5'h00, s.irq_mask};
    end
    return b;
  endfunction : read_byte

  // Decode of modes and refresh conditions
  always_comb begin
    read_mode = st.cfg[cfg_index(ADDR_LINK_STATE_CONTROL)][READ_MODE_LSB +: 2];
    ready_sel = st.cfg[cfg_index(ADDR_LINK_STATE_CONTROL)][READY_SEL_LSB +: 2];
    eff_addr = (cont_in && st.session == READING) ? st.ptr : addr_in;
    both_new = st.pnew0 && st.pnew1;
    if (ready_sel == READY_LINKED) begin
      upd0 = sample_rate_tick_in && both_new;
      upd1 = sample_rate_tick_in && both_new;
    end else begin
      upd0 = sample_rate_tick_in && st.pnew0;
      upd1 = sample_rate_tick_in && st.pnew1;
    end
    unique case (ready_sel)
      READY_LINKED: ready_event = upd0 && upd1;
      READY_CHAN0: ready_event = upd0;
      READY_CHAN1: ready_event = upd1;
      default: ready_event = upd0 || upd1;
    endcase
  end

  // Next state of the whole bank
  always_comb begin
    next_st = st;
    next_st.strobe = 1'b0;
    if (ce_in) begin
      // Pending result capture; a new valid wins over the tick's clear
      if (upd0) next_st.pnew0 = 1'b0;
      if (upd1) next_st.pnew1 = 1'b0;
      if (conv0_valid_in) begin
        next_st.pend0 = conv0_data_in;
        next_st.pnew0 = 1'b1;
      end
      if (conv1_valid_in) begin
        next_st.pend1 = conv1_data_in;
        next_st.pnew1 = 1'b1;
      end
      // All three bytes move together on the tick
      if (upd0) next_st.live0 = st.pend0;
      if (upd1) next_st.live1 = st.pend1;
      next_st.strobe = ready_event;
      // Register reads; a fresh read latches first so its byte is current
      if (rd_in) begin
        if (!(cont_in && st.session == READING)) begin
          next_st.hold0 = st.live0;
          next_st.hold1 = st.live1;
          next_st.session = READING;
        end
        next_st.rdata = read_byte(eff_addr, next_st);
        next_st.ptr = next_addr(eff_addr, read_mode);
      end
      // Register writes; results and reserved byte ignore them
      if (wr_in) begin
        next_st.session = IDLE;
        if (addr_in >= ADDR_INTERCHANNEL_DELAY && addr_in <= ADDR_SETUP_TWO) begin
          next_st.cfg[cfg_index(addr_in)] = wdata_in;
        end
        if (addr_in == ADDR_IRQ_MASK) begin
          next_st.irq_mask = wdata_in[IRQ_W-1:0];
        end
        if (addr_in == ADDR_IRQ_STATUS) begin
          next_st.irq_status = st.irq_status & ~wdata_in[IRQ_W-1:0];
        end
      end
      // Sticky events, set wins over clear
      if (upd0) next_st.irq_status[IRQ_CHAN0] = 1'b1;
      if (upd1) next_st.irq_status[IRQ_CHAN1] = 1'b1;
      if (ready_event) next_st.irq_status[IRQ_READY] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '{
        session: IDLE,
        live0: RESULT_RESET,
        live1: RESULT_RESET,
        pend0: RESULT_RESET,
        pend1: RESULT_RESET,
        pnew0: 1'b0,
        pnew1: 1'b0,
        hold0: RESULT_RESET,
        hold1: RESULT_RESET,
        cfg: {CFG_COUNT{CFG_RESET}},
        ptr: 4'h0,
        rdata: 8'h00,
        irq_status: IRQ_RESET,
        irq_mask: IRQ_RESET,
        strobe: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign rdata_out = st.rdata;
  assign conversion_ready_strobe_out = st.strobe;
  assign irq_out = |(st.irq_status & st.irq_mask);
  assign interchannel_delay_out = st.cfg[cfg_index(ADDR_INTERCHANNEL_DELAY)];
  assign amp_setting_out = st.cfg[cfg_index(ADDR_AMP_SETTING)];
  assign setup_one_out = st.cfg[cfg_index(ADDR_SETUP_ONE)];
  assign setup_two_out = st.cfg[cfg_index(ADDR_SETUP_TWO)];

  // Checks on the bank
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_result_only_tick: assert property (
    !($past(ce_in) && $past(upd0)) |-> $stable(st.live0))
    else $error("Channel 0 result changed without a tick");

  a_bytes_together: assert property (
    (st.live1[23:16] != $past(st.live1[23:16])) |-> (st.live1 == $past(st.pend1)))
    else $error("Channel 1 result bytes not refreshed together");

  a_hold_during_read: assert property (
    ce_in && rd_in && cont_in && st.session == READING |=> $stable(st.hold0) && $stable(st.hold1))
    else $error("Held results changed during a continuous read");

  a_newest_captured: assert property (
    ce_in && conv0_valid_in && st.session == READING |=> st.pnew0 && st.pend0 == $past(conv0_data_in))
    else $error("Conversion during a read was lost");

  a_msb_first: assert property (
    ce_in && rd_in && !cont_in && addr_in == ADDR_CHAN0_RESULT |=> rdata_out == st.hold0[23:16])
    else $error("Channel 0 MSB not at lowest address");

  a_reserved_zero: assert property (
    ce_in && rd_in && !cont_in && addr_in == ADDR_RESERVED_SLOT |=> rdata_out == 8'h00)
    else $error("Reserved byte did not read zero");

  a_full_wrap: assert property (
    ce_in && rd_in && read_mode == READ_ALL && eff_addr == ADDR_SETUP_TWO |=> st.ptr == 4'h0)
    else $error("Whole map walk did not wrap");

  a_skip_reserved: assert property (
    ce_in && rd_in && read_mode == READ_ALL && eff_addr == 4'h5 |=> st.ptr == 4'h7)
    else $error("Walk did not skip the reserved byte");

  a_group_loop: assert property (
    ce_in && rd_in && read_mode == READ_GROUP && eff_addr == 4'h2 |=> st.ptr == 4'h0)
    else $error("Group walk did not loop");

  a_type_loop: assert property (
    ce_in && rd_in && read_mode == READ_TYPE && eff_addr == 4'h5 |=> st.ptr == 4'h0)
    else $error("Type walk did not loop");

  a_linked_strobe: assert property (
    ce_in && ready_sel == READY_LINKED && sample_rate_tick_in && !both_new
    |=> !conversion_ready_strobe_out)
    else $error("Linked strobe issued without both samples");

  a_config_write: assert property (
    ce_in && wr_in && addr_in == ADDR_AMP_SETTING |=> amp_setting_out == $past(wdata_in))
    else $error("Amplifier setting not written");

  a_irq_raise: assert property (
    ce_in && upd0 && st.irq_mask[IRQ_CHAN0] |=> irq_out)
    else $error("Interrupt not raised on channel 0 refresh");

  a_chan1_msb: assert property (
    ce_in && rd_in && !cont_in && addr_in == ADDR_CHAN1_RESULT |=> rdata_out == st.hold1[23:16])
    else $error("Channel 1 MSB not at its lowest address");

  a_rdata_held: assert property (
    !(ce_in && rd_in) |=> $stable(rdata_out))
    else $error("Read data moved without a read");

  a_hold_on_open: assert property (
    ce_in && rd_in && !(cont_in && st.session == READING)
    |=> st.hold0 == $past(st.live0) && st.hold1 == $past(st.live1))
    else $error("Results not latched at start of a read");

  a_newest_ch1: assert property (
    ce_in && conv1_valid_in && st.session == READING |=> st.pnew1 && st.pend1 == $past(conv1_data_in))
    else $error("Channel 1 conversion during a read was lost");

  a_linked_refresh: assert property (
    ce_in && ready_sel == READY_LINKED && sample_rate_tick_in && both_new
    |=> conversion_ready_strobe_out && st.live0 == $past(st.pend0) && st.live1 == $past(st.pend1))
    else $error("Linked refresh did not move both results");

  a_chain_step: assert property (
    ce_in && rd_in && read_mode == READ_ALL && eff_addr < ADDR_SETUP_TWO && eff_addr != 4'h5
    |=> st.ptr == $past(eff_addr) + 4'h1)
    else $error("Whole map walk did not step by one");

  a_static_stay: assert property (
    ce_in && rd_in && read_mode == READ_STATIC && eff_addr != ADDR_RESERVED_SLOT
    |=> st.ptr == $past(eff_addr))
    else $error("Static read mode moved the pointer");

  c_linked_strobe: cover property (
    ready_sel == READY_LINKED && conversion_ready_strobe_out);
  c_full_walk_wrap: cover property (
    ce_in && rd_in && cont_in && read_mode == READ_ALL && eff_addr == ADDR_SETUP_TWO);
  c_conv_during_read: cover property (
    st.session == READING && ce_in && conv1_valid_in ##1 ce_in && rd_in && cont_in);
  c_irq_clear: cover property (
    irq_out ##1 ce_in && wr_in && addr_in == ADDR_IRQ_STATUS ##1 !irq_out);

endmodule : afe_register_map_readout

// ===== core/afe_regs_pkg.sv
package afe_regs_pkg;

  // Register byte addresses
  localparam logic [3:0] ADDR_CHAN0_RESULT = 4'h0;
  localparam logic [3:0] ADDR_CHAN1_RESULT = 4'h3;
  localparam logic [3:0] ADDR_RESERVED_SLOT = 4'h6;
  localparam logic [3:0] ADDR_INTERCHANNEL_DELAY = 4'h7;
  localparam logic [3:0] ADDR_AMP_SETTING = 4'h8;
  localparam logic [3:0] ADDR_LINK_STATE_CONTROL = 4'h9;
  localparam logic [3:0] ADDR_SETUP_ONE = 4'hA;
  localparam logic [3:0] ADDR_SETUP_TWO = 4'hB;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'hC;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hD;
  localparam logic [3:0] ADDR_LAST_MAPPED = 4'hB;

  // Widths
  localparam int BYTE_W = 8;
  localparam int RESULT_W = 24;
  localparam int CFG_COUNT = 5;
  localparam int IRQ_W = 3;

  // Fields of link_state_control
  localparam int READ_MODE_LSB = 6;
  localparam int READY_SEL_LSB = 2;

  // Read mode encodings
  localparam logic [1:0] READ_STATIC = 2'h0;
  localparam logic [1:0] READ_GROUP = 2'h1;
  localparam logic [1:0] READ_TYPE = 2'h2;
  localparam logic [1:0] READ_ALL = 2'h3;

  // Ready pin selection encodings
  localparam logic [1:0] READY_LINKED = 2'h0;
  localparam logic [1:0] READY_CHAN0 = 2'h1;
  localparam logic [1:0] READY_CHAN1 = 2'h2;
  localparam logic [1:0] READY_EITHER = 2'h3;

  // Interrupt status bit positions
  localparam int IRQ_CHAN0 = 0;
  localparam int IRQ_CHAN1 = 1;
  localparam int IRQ_READY = 2;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [23:0] RESULT_RESET = 24'h000000;
  localparam logic [2:0] IRQ_RESET = 3'h0;

endpackage : afe_regs_pkg

// ===== tb/afe_register_map_readout_bench.sv
`timescale 1ns/100ps
module afe_register_map_readout_bench;
  import afe_regs_pkg::*;
  logic clk_in, rst_in, wr, rd, cont, c0v, c1v, tick, strobe, irq, ce;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, dly, amp, s1, s2, d, lsc;
  logic [23:0] c0d, c1d;
  logic [47:0] res;
  logic [1:0] md [7] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
  logic [3:0] st [7] = '{4'hB, 4'h5, 4'h2, 4'h7, 4'h5, 4'hB, 4'h1};
  logic [3:0] nx [7] = '{4'h0, 4'h7, 4'h0, 4'h7, 4'h0, 4'h7, 4'h1};
  int miscompares = 0;
  int compares = 0;

  afe_register_map_readout uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .cont_in(cont),
    .rdata_out(rdata), .conv0_valid_in(c0v), .conv0_data_in(c0d),
    .conv1_valid_in(c1v), .conv1_data_in(c1d), .sample_rate_tick_in(tick),
    .conversion_ready_strobe_out(strobe), .irq_out(irq),
    .interchannel_delay_out(dly), .amp_setting_out(amp),
    .setup_one_out(s1), .setup_two_out(s2));

  conv_source src (.clk_in(clk_in), .conv0_valid_out(c0v), .conv0_data_out(c0d),
    .conv1_valid_out(c1v), .conv1_data_out(c1d), .tick_out(tick));

  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task check(input string n, input logic [23:0] s, input logic [23:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // Host writes; 0x06 is never a target
  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  // Read byte lands in the cycle after the strobe
  task rd_reg(input logic [3:0] a, input logic c);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    cont <= c;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Expected byte at an address
  function automatic logic [7:0] exp_byte(input logic [3:0] a);
    if (a < 4'h6) return res[47 - 8 * a -: 8];
    if (a == 4'h9) return lsc;
    return 8'h30 + {4'h0, a};
  endfunction : exp_byte

  task t_reset;
    for (int a = 7; a < 14; a++) begin
      rd_reg(a[3:0], 1'b0);
      check("reset value", d, 24'h0);
    end
    $display("done t_reset");
  endtask : t_reset

  task t_rw;
    for (int a = 7; a < 12; a++) wr_reg(a[3:0], 8'h30 + a[7:0]);
    for (int a = 7; a < 12; a++) begin
      rd_reg(a[3:0], 1'b0);
      check("rw readback", d, 8'h30 + a[7:0]);
    end
    check("delay out", dly, 8'h37);
    check("amp out", amp, 8'h38);
    check("setup one out", s1, 8'h3A);
    check("setup two out", s2, 8'h3B);
    lsc = 8'h00;
    wr_reg(ADDR_LINK_STATE_CONTROL, lsc);
    wr_reg(4'h0, 8'hFF);
    rd_reg(4'h0, 1'b0);
    check("result write ignored", d, 8'h00);
    rd_reg(4'hE, 1'b0);
    check("unmapped", d, 8'h00);
    $display("done t_rw");
  endtask : t_rw

  task t_conv;
    src.push(1'b1, 1'b0, 24'hA1B2C3, 24'h0);
    #1 check("no lone strobe", strobe, 1'b0);
    src.push(1'b0, 1'b1, 24'h0, 24'hD4E5F6);
    #1 check("linked strobe", strobe, 1'b1);
    @(posedge clk_in);
    #1 check("strobe width", strobe, 1'b0);
    res = {24'hA1B2C3, 24'hD4E5F6};
    for (int a = 0; a < 6; a++) begin
      rd_reg(a[3:0], 1'b0);
      check("result byte", d, exp_byte(a[3:0]));
    end
    $display("done t_conv");
  endtask : t_conv

  task t_modes;
    for (int i = 0; i < 7; i++) begin
      lsc = {md[i], 6'h00};
      wr_reg(ADDR_LINK_STATE_CONTROL, lsc);
      rd_reg(st[i], 1'b0);
      check("start byte", d, exp_byte(st[i]));
      rd_reg(4'h0, 1'b1);
      check("next byte", d, exp_byte(nx[i]));
    end
    $display("done t_modes");
  endtask : t_modes

  task t_latch;
    lsc = 8'hC0;
    wr_reg(ADDR_LINK_STATE_CONTROL, lsc);
    rd_reg(4'h0, 1'b0);
    check("latched first", d, 8'hA1);
    src.push(1'b1, 1'b1, 24'h112233, 24'h445566);
    #1 check("strobe in read", strobe, 1'b1);
    rd_reg(4'h0, 1'b1);
    check("latched kept", d, 8'hB2);
    rd_reg(4'h3, 1'b0);
    check("newest ch1", d, 8'h44);
    rd_reg(4'h0, 1'b1);
    check("newest chain", d, 8'h55);
    $display("done t_latch");
  endtask : t_latch

  task t_irq;
    rd_reg(ADDR_IRQ_STATUS, 1'b0);
    check("irq status", d, 8'h07);
    check("irq masked", irq, 1'b0);
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    #1 check("irq raised", irq, 1'b1);
    wr_reg(ADDR_IRQ_STATUS, 8'h01);
    #1 check("irq cleared", irq, 1'b0);
    rd_reg(ADDR_IRQ_STATUS, 1'b0);
    check("irq status left", d, 8'h06);
    wr_reg(ADDR_IRQ_MASK, 8'h04);
    #1 check("irq strobe bit", irq, 1'b1);
    wr_reg(ADDR_IRQ_STATUS, 8'h04);
    #1 check("irq final", irq, 1'b0);
    $display("done t_irq");
  endtask : t_irq

  // Ready selections 01, 10 and 11, with one channel refreshed on its own
  task t_ready;
    lsc = 8'h04;
    wr_reg(ADDR_LINK_STATE_CONTROL, lsc);
    src.push(1'b1, 1'b0, 24'h0A0B0C, 24'h0);
    #1 check("ch0 select strobe", strobe, 1'b1);
    lsc = 8'h08;
    wr_reg(ADDR_LINK_STATE_CONTROL, lsc);
    src.push(1'b1, 1'b0, 24'h0D0E0F, 24'h0);
    #1 check("ch1 select quiet", strobe, 1'b0);
    src.push(1'b0, 1'b1, 24'h0, 24'h102030);
    #1 check("ch1 select strobe", strobe, 1'b1);
    lsc = 8'h0C;
    wr_reg(ADDR_LINK_STATE_CONTROL, lsc);
    src.push(1'b1, 1'b0, 24'h405060, 24'h0);
    #1 check("either strobe", strobe, 1'b1);
    rd_reg(ADDR_CHAN0_RESULT, 1'b0);
    check("lone ch0 refresh", d, 8'h40);
    rd_reg(ADDR_CHAN1_RESULT, 1'b0);
    check("lone ch1 refresh", d, 8'h10);
    $display("done t_ready");
  endtask : t_ready

  // Enable low drops a write; a reset in mid run clears the bank
  task t_freeze;
    @(posedge clk_in);
    ce <= 1'b0;
    wr <= 1'b1;
    addr <= ADDR_AMP_SETTING;
    wdata <= 8'h5A;
    @(posedge clk_in);
    ce <= 1'b1;
    wr <= 1'b0;
    #1 check("frozen write", amp, 8'h38);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 check("mid reset amp", amp, 8'h00);
    check("mid reset irq", irq, 1'b0);
    rd_reg(ADDR_SETUP_ONE, 1'b0);
    check("mid reset setup", d, 8'h00);
    $display("done t_freeze");
  endtask : t_freeze

  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Watchdog
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    rst_in = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    cont = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    lsc = 8'h00;
    res = 48'h0;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_rw();
    t_conv();
    t_modes();
    t_latch();
    t_irq();
    t_ready();
    t_freeze();
    end_sim();
  end
endmodule : afe_register_map_readout_bench

// ===== tb/conv_source.sv
`timescale 1ns/100ps
module conv_source (
  // Clock
  input wire logic clk_in,
  // Conversion results and rate tick
  output logic conv0_valid_out,
  output logic [23:0] conv0_data_out,
  output logic conv1_valid_out,
  output logic [23:0] conv1_data_out,
  output logic tick_out
);
  // Idle at time zero
  initial begin
    conv0_valid_out = 1'b0;
    conv1_valid_out = 1'b0;
    conv0_data_out = 24'h000000;
    conv1_data_out = 24'h000000;
    tick_out = 1'b0;
  end

  // One conversion per flagged channel, then one rate tick
  task automatic push(input logic m0, input logic m1, input logic [23:0] d0,
                      input logic [23:0] d1);
    @(posedge clk_in);
    conv0_valid_out <= m0;
    conv1_valid_out <= m1;
    conv0_data_out <= d0;
    conv1_data_out <= d1;
    @(posedge clk_in);
    conv0_valid_out <= 1'b0;
    conv1_valid_out <= 1'b0;
    // Stale data lines are scrambled, never held
    conv0_data_out <= ~d0;
    conv1_data_out <= ~d1;
    tick_out <= 1'b1;
    @(posedge clk_in);
    tick_out <= 1'b0;
  endtask : push
endmodule : conv_source
